/* src/pmsmi_status.sv */
`timescale 1ns/1ps
`default_nettype none
module pmsmi_status
  import pmsmi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire pmsmi_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire pmsmi_trap_evt_t trap_evt,
  input wire logic vga_timer_expire,
  input wire logic [PMSMI_NUM_GP-1:0] gp_pin,
  input wire logic [PMSMI_NUM_GP-1:0] gp_func_en,
  input wire logic lid_switch_pin,
  input wire logic codec_sdata_in,
  input wire logic rtc_irq8,
  input wire logic suspend_3v,
  input wire logic acpi_tmr_msb,
  output logic smi_req,
  output logic top_smi_status,
  output logic vga_timer_smi
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] pm_ctrl;
  logic [7:0] trap_en;
  logic [7:0] trap_en2;
  logic [7:0] gp_dir;
  logic [7:0] gp_smi_en;
  logic wr_pm_ctrl;
  logic wr_trap_en;
  logic wr_trap_en2;
  logic wr_gp_dir;
  logic wr_gp_smi_en;

  // Writes to the status indices match none of these strobes and are dropped.
  assign wr_pm_ctrl = cfg_req.wr && (cfg_req.index == PMSMI_IDX_PM_CTRL);
  assign wr_trap_en = cfg_req.wr && (cfg_req.index == PMSMI_IDX_TRAP_EN);
  assign wr_trap_en2 = cfg_req.wr && (cfg_req.index == PMSMI_IDX_TRAP_EN2);
  assign wr_gp_dir = cfg_req.wr && (cfg_req.index == PMSMI_IDX_GP_DIR);
  assign wr_gp_smi_en = cfg_req.wr && (cfg_req.index == PMSMI_IDX_GP_SMI_EN);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pm_ctrl <= PMSMI_RST_CFG;
    end else if (wr_pm_ctrl) begin
      pm_ctrl <= cfg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trap_en <= PMSMI_RST_CFG;
    end else if (wr_trap_en) begin
      trap_en <= cfg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trap_en2 <= PMSMI_RST_CFG;
    end else if (wr_trap_en2) begin
      trap_en2 <= cfg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gp_dir <= PMSMI_RST_CFG;
    end else if (wr_gp_dir) begin
      gp_dir <= cfg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gp_smi_en <= PMSMI_RST_CFG;
    end else if (wr_gp_smi_en) begin
      gp_smi_en <= cfg_req.wdata;
    end
  end

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [PMSMI_NUM_GP-1:0] gp_toggle;
  logic lid_level;
  logic lid_toggle;
  logic codec_rise;
  logic irq8_rise;
  logic acpi_toggle;

  // One synchroniser per source keeps the edge kind that each event uses visible here.
  pmsmi_edge_sync #(
    .WIDTH(PMSMI_NUM_GP)
  ) u_gp_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(gp_pin),
    .level(),
    .rise(),
    .toggle(gp_toggle)
  );

  pmsmi_edge_sync #(
    .WIDTH(1)
  ) u_lid_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(lid_switch_pin),
    .level(lid_level),
    .rise(),
    .toggle(lid_toggle)
  );

  pmsmi_edge_sync #(
    .WIDTH(1)
  ) u_codec_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(codec_sdata_in),
    .level(),
    .rise(codec_rise),
    .toggle()
  );

  pmsmi_edge_sync #(
    .WIDTH(1)
  ) u_alarm_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(rtc_irq8),
    .level(),
    .rise(irq8_rise),
    .toggle()
  );

  pmsmi_edge_sync #(
    .WIDTH(1)
  ) u_acpi_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(acpi_tmr_msb),
    .level(),
    .rise(),
    .toggle(acpi_toggle)
  );

  // ****************************************
  // Trap status event sources
  // ****************************************
  logic [7:0] trap_set;
  logic global_trap;

  // The global trap enable gates every access trap but never the idle timer.
  assign global_trap = pm_ctrl[PMSMI_B_GLOBAL_TRAP];

  always_comb begin
    trap_set = '0;
    trap_set[PMSMI_B_VIDEO_TRAP] = trap_evt.video_trap & trap_en[PMSMI_B_VIDEO_TRAP] & global_trap;
    trap_set[PMSMI_B_ST_SEC_TRAP] = trap_evt.sec_disk_trap & trap_en2[PMSMI_B_SEC_TRAP_EN] & global_trap;
    trap_set[PMSMI_B_ST_SEC_IDLE] = trap_evt.sec_disk_idle & trap_en2[PMSMI_B_SEC_IDLE_EN];
    trap_set[PMSMI_B_KBD_TRAP] = trap_evt.kbd_mouse_trap & trap_en[PMSMI_B_KBD_TRAP] & global_trap;
    trap_set[PMSMI_B_SERPAR_TRAP] = trap_evt.ser_par_trap & trap_en[PMSMI_B_SERPAR_TRAP] & global_trap;
    trap_set[PMSMI_B_FLOPPY_TRAP] = trap_evt.floppy_trap & trap_en[PMSMI_B_FLOPPY_TRAP] & global_trap;
    trap_set[PMSMI_B_PRI_TRAP] = trap_evt.pri_disk_trap & trap_en[PMSMI_B_PRI_TRAP] & global_trap;
  end

  // ****************************************
  // Miscellaneous status event sources
  // ****************************************
  logic [7:0] misc_set;
  logic [PMSMI_NUM_GP-1:0] gp_qualified;

  assign gp_qualified = gp_func_en & ~gp_dir[PMSMI_NUM_GP-1:0] & gp_smi_en[PMSMI_NUM_GP-1:0];

  always_comb begin
    misc_set = '0;
    misc_set[PMSMI_B_MISC_GP_LO +: PMSMI_NUM_GP] = gp_toggle & gp_qualified;
    misc_set[PMSMI_B_MISC_LID_EVT] = lid_toggle & ~gp_dir[PMSMI_B_LID] & gp_smi_en[PMSMI_B_LID];
    misc_set[PMSMI_B_MISC_CODEC] = codec_rise & pm_ctrl[PMSMI_B_CODEC_EN];
    misc_set[PMSMI_B_MISC_ALARM] = irq8_rise & suspend_3v;
    misc_set[PMSMI_B_MISC_ACPI] = acpi_toggle & trap_en2[PMSMI_B_ACPI_EN];
  end

  // ****************************************
  // Status bytes with read-to-clear
  // ****************************************
  logic trap_clr_rd;
  logic misc_clr_rd;
  logic [7:0] trap_status;
  logic [7:0] misc_status;
  logic [7:0] next_trap_status;
  logic [7:0] next_misc_status;

  assign trap_clr_rd = cfg_req.rd && (cfg_req.index == PMSMI_IDX_TRAP_CLR);
  assign misc_clr_rd = cfg_req.rd && (cfg_req.index == PMSMI_IDX_MISC_CLR);

  always_comb begin
    next_trap_status = trap_status;
    if (trap_clr_rd) begin
      next_trap_status = '0;
    end
    next_trap_status = (next_trap_status | trap_set) & PMSMI_TRAP_VALID;
  end

  always_comb begin
    next_misc_status = misc_status;
    if (misc_clr_rd) begin
      next_misc_status = '0;
    end
    next_misc_status = (next_misc_status | misc_set) & PMSMI_MISC_EVENTS;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trap_status <= PMSMI_RST_STATUS;
    end else begin
      trap_status <= next_trap_status;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      misc_status <= PMSMI_RST_STATUS;
    end else begin
      misc_status <= next_misc_status;
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  logic [7:0] misc_view;
  logic [7:0] next_rdata;

  always_comb begin
    misc_view = misc_status;
    misc_view[PMSMI_B_MISC_LID_POS] = lid_level & gp_smi_en[PMSMI_B_LID];
  end

  // Read data shows the value sampled before the clear takes effect.
  always_comb begin
    unique case (cfg_req.index)
      PMSMI_IDX_PM_CTRL: begin
        next_rdata = pm_ctrl;
      end
      PMSMI_IDX_TRAP_EN: begin
        next_rdata = trap_en;
      end
      PMSMI_IDX_TRAP_EN2: begin
        next_rdata = trap_en2;
      end
      PMSMI_IDX_GP_DIR: begin
        next_rdata = gp_dir;
      end
      PMSMI_IDX_GP_SMI_EN: begin
        next_rdata = gp_smi_en;
      end
      PMSMI_IDX_TRAP_MIRROR, PMSMI_IDX_TRAP_CLR: begin
        next_rdata = trap_status;
      end
      PMSMI_IDX_MISC_MIRROR, PMSMI_IDX_MISC_CLR: begin
        next_rdata = misc_view;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
    end
  end

  // Read data holds between reads, so the handler may sample it late.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_req.rd) begin
      cfg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Request outputs
  // ****************************************
  logic any_status;

  assign any_status = (|next_trap_status) | (|next_misc_status);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      smi_req <= 1'b0;
    end else begin
      smi_req <= any_status;
    end
  end

  // The summary bit has its own flop so that it can later be masked apart from the request.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      top_smi_status <= 1'b0;
    end else begin
      top_smi_status <= any_status;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vga_timer_smi <= 1'b0;
    end else begin
      vga_timer_smi <= vga_timer_expire & trap_en2[PMSMI_B_VGA_EN];
    end
  end

endmodule
`default_nettype wire

/* src/pmsmi_pkg.sv */
package pmsmi_pkg;

  // ****************************************
  // Configuration indices
  // ****************************************
  localparam logic [7:0] PMSMI_IDX_PM_CTRL = 8'h80;
  localparam logic [7:0] PMSMI_IDX_TRAP_EN = 8'h82;
  localparam logic [7:0] PMSMI_IDX_TRAP_EN2 = 8'h83;
  localparam logic [7:0] PMSMI_IDX_TRAP_MIRROR = 8'h86;
  localparam logic [7:0] PMSMI_IDX_MISC_MIRROR = 8'h87;
  localparam logic [7:0] PMSMI_IDX_GP_DIR = 8'h90;
  localparam logic [7:0] PMSMI_IDX_GP_SMI_EN = 8'h92;
  localparam logic [7:0] PMSMI_IDX_TRAP_CLR = 8'hF6;
  localparam logic [7:0] PMSMI_IDX_MISC_CLR = 8'hF7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PMSMI_B_GLOBAL_TRAP = 2;
  localparam int PMSMI_B_CODEC_EN = 5;
  localparam int PMSMI_B_VGA_EN = 3;
  localparam int PMSMI_B_ACPI_EN = 5;
  localparam int PMSMI_B_SEC_TRAP_EN = 6;
  localparam int PMSMI_B_SEC_IDLE_EN = 7;
  localparam int PMSMI_B_LID = 6;
  localparam int PMSMI_B_MISC_LID_POS = 4;
  localparam int PMSMI_B_TRAP_RSVD = 6;
  localparam int PMSMI_B_VIDEO_TRAP = 7;
  localparam int PMSMI_B_ST_SEC_TRAP = 5;
  localparam int PMSMI_B_ST_SEC_IDLE = 4;
  localparam int PMSMI_B_KBD_TRAP = 3;
  localparam int PMSMI_B_SERPAR_TRAP = 2;
  localparam int PMSMI_B_FLOPPY_TRAP = 1;
  localparam int PMSMI_B_PRI_TRAP = 0;
  localparam int PMSMI_B_MISC_GP_LO = 5;
  localparam int PMSMI_B_MISC_LID_EVT = 3;
  localparam int PMSMI_B_MISC_CODEC = 2;
  localparam int PMSMI_B_MISC_ALARM = 1;
  localparam int PMSMI_B_MISC_ACPI = 0;

  // ****************************************
  // Reset values and masks
  // ****************************************
  localparam logic [7:0] PMSMI_RST_CFG = 8'h00;
  localparam logic [7:0] PMSMI_RST_STATUS = 8'h00;
  localparam logic [7:0] PMSMI_TRAP_VALID = 8'hBF;
  localparam logic [7:0] PMSMI_MISC_EVENTS = 8'hEF;
  localparam int PMSMI_NUM_GP = 3;

  // Access trap and idle expiry pulses from the trap decoders and idle timers.
  typedef struct packed {
    logic video_trap;
    logic sec_disk_trap;
    logic sec_disk_idle;
    logic kbd_mouse_trap;
    logic ser_par_trap;
    logic floppy_trap;
    logic pri_disk_trap;
  } pmsmi_trap_evt_t;

  // Configuration-space access from the PCI target.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] index;
    logic [7:0] wdata;
  } pmsmi_cfg_req_t;

endpackage

/* src/pmsmi_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pmsmi_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] toggle
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  // The first stage feeds only the second; edges are taken from later stages.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= din;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level = sync;
  assign rise = sync & ~prev;
  assign toggle = sync ^ prev;
endmodule
`default_nettype wire

/* tb/pmsmi_status_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pmsmi_status_checker
  import pmsmi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire pmsmi_cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  input wire pmsmi_trap_evt_t trap_evt,
  input wire logic vga_timer_expire,
  input wire logic smi_req,
  input wire logic top_smi_status,
  input wire logic vga_timer_smi
);
  logic [7:0] en80;
  logic [7:0] en82;
  logic [7:0] en83;
  logic hit;
  // The checker cannot see the register file, so it keeps its own copy of the enables.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en80 <= 8'h00;
      en82 <= 8'h00;
      en83 <= 8'h00;
    end else if (cfg_req.wr) begin
      if (cfg_req.index == 8'h80) en80 <= cfg_req.wdata;
      if (cfg_req.index == 8'h82) en82 <= cfg_req.wdata;
      if (cfg_req.index == 8'h83) en83 <= cfg_req.wdata;
    end
  end
  assign hit = (en80[2] && |({trap_evt[6:5], trap_evt[3:0]} & {en82[7], en83[6], en82[3:0]}))
    || (trap_evt[4] && en83[7]);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_trap_sets_req: assert property (hit |=> smi_req)
    else $error("enabled trap event did not raise the request");
  a_top_equals_req: assert property (top_smi_status == smi_req)
    else $error("summary bit differs from request");
  a_req_falls_read: assert property ($fell(smi_req) |-> $past(cfg_req.rd && cfg_req.index inside {8'hF6, 8'hF7}))
    else $error("request fell without a clearing read");
  a_reserved_zero: assert property (cfg_req.rd && cfg_req.index inside {8'h86, 8'hF6} |=> !cfg_rdata[6])
    else $error("reserved trap bit read as one");
  a_vga_pulse: assert property (vga_timer_smi == $past(vga_timer_expire && en83[3]))
    else $error("graphics timer output wrong");
  a_rvalid_after_rd: assert property (cfg_req.rd |=> cfg_rvalid)
    else $error("read not answered after one cycle");
  a_rvalid_only_rd: assert property (cfg_rvalid |-> $past(cfg_req.rd))
    else $error("read valid without a read");
  a_rdata_hold: assert property (!$past(cfg_req.rd) |-> $stable(cfg_rdata))
    else $error("read data changed without a read");
  c_trap_clear: cover property (cfg_req.rd && cfg_req.index == 8'hF6 && smi_req);
  c_misc_clear: cover property (cfg_req.rd && cfg_req.index == 8'hF7 && smi_req);
  c_vga_out: cover property (vga_timer_smi);
endmodule
bind pmsmi_status pmsmi_status_checker u_chk (.clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .trap_evt(trap_evt), .vga_timer_expire(vga_timer_expire),
  .smi_req(smi_req), .top_smi_status(top_smi_status), .vga_timer_smi(vga_timer_smi));
`default_nettype wire

/* tb/pmsmi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmsmi_host_model
  import pmsmi_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rvalid,
  output var pmsmi_cfg_req_t cfg_req
);
  // An idle edge follows every access so the strobe is never reassigned in one time step.
  initial cfg_req = '0;
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cfg_req = '{rd: 1'h0, wr: 1'h1, index: idx, wdata: d};
    @(posedge clk_sys);
    #1;
    cfg_req = '0;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic v);
    cfg_req = '{rd: 1'h1, wr: 1'h0, index: idx, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    cfg_req = '0;
    d = cfg_rdata;
    v = cfg_rvalid;
    @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pmsmi_pkg::*;
();
  typedef struct packed {logic [7:0] e80; logic [7:0] e82; logic [7:0] e83; logic [6:0] evt; logic [7:0] exp;} pmsmi_row_t;
  logic clk_sys, rst, cfg_rvalid, vga_timer_expire, rd_ok;
  logic lid_switch_pin, codec_sdata_in, rtc_irq8, suspend_3v, acpi_tmr_msb;
  logic smi_req, top_smi_status, vga_timer_smi;
  logic [7:0] cfg_rdata, rd_val;
  logic [2:0] gp_pin, gp_func_en;
  pmsmi_cfg_req_t cfg_req;
  pmsmi_trap_evt_t trap_evt;
  int err_count, n_tests;
  pmsmi_row_t rows [9] = '{'{8'h04, 8'h01, 8'h00, 7'h01, 8'h01}, '{8'h04, 8'h02, 8'h00, 7'h02, 8'h02},
    '{8'h04, 8'h04, 8'h00, 7'h04, 8'h04}, '{8'h04, 8'h08, 8'h00, 7'h08, 8'h08},
    '{8'h04, 8'h00, 8'h80, 7'h10, 8'h10}, '{8'h04, 8'h00, 8'h40, 7'h20, 8'h20},
    '{8'h04, 8'hF0, 8'h00, 7'h0F, 8'h00}, '{8'h04, 8'hFF, 8'hC0, 7'h7F, 8'hBF},
    '{8'h00, 8'h0F, 8'h80, 7'h1F, 8'h10}};
  pmsmi_status dut (.clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .trap_evt(trap_evt), .vga_timer_expire(vga_timer_expire), .gp_pin(gp_pin),
    .gp_func_en(gp_func_en), .lid_switch_pin(lid_switch_pin), .codec_sdata_in(codec_sdata_in),
    .rtc_irq8(rtc_irq8), .suspend_3v(suspend_3v), .acpi_tmr_msb(acpi_tmr_msb), .smi_req(smi_req),
    .top_smi_status(top_smi_status), .vga_timer_smi(vga_timer_smi));
  pmsmi_host_model host (.clk_sys(clk_sys), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .cfg_req(cfg_req));
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e, input string nm);
    host.rd(idx, rd_val, rd_ok);
    chk1("cfg_rvalid", 1'h1, rd_ok);
    chk8(nm, e, rd_val);
  endtask
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Watchdog, over twenty times the expected run
  // ****************************************
  initial begin
    #20000;
    err_count++;
    end_of_test();
  end
  initial begin
    {rst, vga_timer_expire, lid_switch_pin, codec_sdata_in, rtc_irq8, suspend_3v, acpi_tmr_msb} = 7'h40;
    {gp_pin, gp_func_en, trap_evt} = 13'h0000;
    err_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'h0;
    rdc(8'hF6, 8'h00, "trap reset");
    rdc(8'hF7, 8'h00, "misc reset");
    foreach (rows[i]) begin
      host.wr(8'h80, rows[i].e80);
      host.wr(8'h82, rows[i].e82);
      host.wr(8'h83, rows[i].e83);
      trap_evt = rows[i].evt;
      tick();
      trap_evt = '0;
      chk1("smi_req", |rows[i].exp, smi_req);
      chk1("top_smi_status", |rows[i].exp, top_smi_status);
      rdc(8'h86, rows[i].exp, "trap mirror");
      rdc(8'hF6, rows[i].exp, "trap clear");
      chk1("smi_req", 1'h0, smi_req);
    end
    host.wr(8'h80, 8'h04);
    host.wr(8'h82, 8'h02);
    trap_evt = 7'h02;
    tick();
    fork
      rdc(8'hF6, 8'h02, "trap first read");
      begin
        tick();
        trap_evt = '0;
      end
    join
    chk1("smi_req", 1'h1, smi_req);
    rdc(8'hF6, 8'h02, "trap event kept");
    rdc(8'hF6, 8'h00, "trap second clear");
    host.wr(8'h92, 8'h47);
    gp_func_en = 3'h7;
    gp_pin = 3'h5;
    lid_switch_pin = 1'h1;
    repeat (4) tick();
    chk1("smi_req", 1'h1, smi_req);
    rdc(8'h87, 8'hB8, "misc mirror");
    rdc(8'hF7, 8'hB8, "misc clear");
    rdc(8'hF7, 8'h10, "misc lid kept");
    chk1("smi_req", 1'h0, smi_req);
    gp_func_en = 3'h0;
    gp_pin = 3'h0;
    host.wr(8'h90, 8'h40);
    lid_switch_pin = 1'h0;
    repeat (4) tick();
    rdc(8'hF7, 8'h00, "misc gated");
    host.wr(8'h80, 8'h20);
    host.wr(8'h83, 8'h20);
    rtc_irq8 = 1'h1;
    repeat (4) tick();
    rtc_irq8 = 1'h0;
    suspend_3v = 1'h1;
    repeat (4) tick();
    {rtc_irq8, codec_sdata_in, acpi_tmr_msb} = 3'h7;
    repeat (4) tick();
    rdc(8'hF7, 8'h07, "misc codec alarm timer");
    {codec_sdata_in, acpi_tmr_msb} = 2'h0;
    repeat (4) tick();
    rdc(8'hF7, 8'h01, "misc falling edges");
    host.wr(8'h80, 8'h00);
    host.wr(8'h83, 8'h08);
    vga_timer_expire = 1'h1;
    tick();
    vga_timer_expire = 1'h0;
    chk1("vga_timer_smi", 1'h1, vga_timer_smi);
    tick();
    chk1("vga_timer_smi", 1'h0, vga_timer_smi);
    end_of_test();
  end
endmodule
`default_nettype wire
